//--- verilog/serial_lane_pkg.sv
// constants, types and helpers for the serial lane crossbar and status block
package serial_lane_pkg;

  // geometry
  localparam int LANES      = 8;
  localparam int SRC_W      = 3;
  localparam int MAP_REGS   = 4;
  localparam int APB_AW     = 12;
  localparam int APB_DW     = 32;
  localparam int IDX_W      = 10;
  localparam int IDX_LSB    = 2;
  localparam int REG_W      = 8;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LANE_MAP_0_1  = 10'h308;
  localparam logic [IDX_W-1:0] IDX_LANE_MAP_2_3  = 10'h309;
  localparam logic [IDX_W-1:0] IDX_LANE_MAP_4_5  = 10'h30A;
  localparam logic [IDX_W-1:0] IDX_LANE_MAP_6_7  = 10'h30B;
  localparam logic [IDX_W-1:0] IDX_FIFO_FULL     = 10'h30C;
  localparam logic [IDX_W-1:0] IDX_FIFO_EMPTY    = 10'h30D;
  localparam logic [IDX_W-1:0] IDX_SYNC_CFG      = 10'h312;
  localparam logic [IDX_W-1:0] IDX_PHY_SETUP     = 10'h314;
  localparam logic [IDX_W-1:0] IDX_PRBS_EN       = 10'h315;
  localparam logic [IDX_W-1:0] IDX_PRBS_CTRL     = 10'h316;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS    = 10'h320;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK      = 10'h321;

  // field positions
  localparam int EVEN_SRC_LSB  = 0;
  localparam int ODD_SRC_LSB   = 3;
  localparam int SYNC_LEN_LSB  = 4;
  localparam int SYNC_LEN_W    = 2;
  localparam int PRBS_CTRL_W   = 7;
  localparam int IRQ_W         = 3;
  localparam int IRQ_SYNC      = 0;
  localparam int IRQ_FULL      = 1;
  localparam int IRQ_EMPTY     = 2;

  // reset values: identity crossbar, lane n reads physical input n
  localparam logic [REG_W-1:0] MAP_0_1_RST   = 8'h08;
  localparam logic [REG_W-1:0] MAP_2_3_RST   = 8'h1A;
  localparam logic [REG_W-1:0] MAP_4_5_RST   = 8'h2C;
  localparam logic [REG_W-1:0] MAP_6_7_RST   = 8'h3E;
  localparam logic [SYNC_LEN_W-1:0] SYNC_LEN_RST = 2'h1;
  localparam logic [REG_W-1:0] PHY_SETUP_RST = 8'h00;
  localparam logic [REG_W-1:0] PRBS_EN_RST   = 8'h00;
  localparam logic [PRBS_CTRL_W-1:0] PRBS_CTRL_RST = 7'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST       = 3'h0;

  // sync error length codes and their cycle counts
  localparam logic [SYNC_LEN_W-1:0] SYNC_LEN_HALF = 2'h0;
  localparam logic [SYNC_LEN_W-1:0] SYNC_LEN_ONE  = 2'h1;
  localparam logic [SYNC_LEN_W-1:0] SYNC_CYC_ONE  = 2'h1;
  localparam logic [SYNC_LEN_W-1:0] SYNC_CYC_TWO  = 2'h2;

  typedef logic [MAP_REGS-1:0][REG_W-1:0] lane_map_t;

  // per logical lane error indications from the decoders
  typedef struct packed {
    logic [LANES-1:0] disparity;
    logic [LANES-1:0] not_in_table;
    logic [LANES-1:0] unexp_ctrl;
  } lane_err_t;

  typedef enum logic {
    SYNC_IDLE,
    SYNC_LOW
  } sync_state_t;

  // source field of a logical lane
  function automatic logic [SRC_W-1:0] lane_src(input lane_map_t m, input int lane);
    logic [REG_W-1:0] r;
    r = m[lane / 2];
    if ((lane % 2) == 1) begin
      lane_src = r[ODD_SRC_LSB +: SRC_W];
    end else begin
      lane_src = r[EVEN_SRC_LSB +: SRC_W];
    end
  endfunction

  // low time in clock cycles; half a cycle cannot be made, one is the least
  function automatic logic [SYNC_LEN_W-1:0] pulse_cycles(input logic [SYNC_LEN_W-1:0] code);
    if (code == SYNC_LEN_HALF || code == SYNC_LEN_ONE) begin
      pulse_cycles = SYNC_CYC_ONE;
    end else begin
      pulse_cycles = SYNC_CYC_TWO;
    end
  endfunction

endpackage

//--- verilog/lane_fifo.sv
// receive fifo for one logical lane with live full and empty flags
`timescale 1ns/1ps
`default_nettype none
module lane_fifo #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 2
) (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              arst_n_in,
  // write side
  input  wire logic              wr_en_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  // read side
  input  wire logic              rd_en_in,
  output logic      [DATA_W-1:0] rd_data_out,
  output logic                   rd_valid_out,
  // flags
  output logic                   full_out,
  output logic                   empty_out
);

  typedef struct packed {
    logic [ADDR_W:0]   wr_ptr;
    logic [ADDR_W:0]   rd_ptr;
    logic [DATA_W-1:0] rd_data;
    logic              rd_valid;
    logic              full;
    logic              empty;
  } fifo_state_t;

  fifo_state_t      st_ff;
  fifo_state_t      nxt_st;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic             do_wr;
  logic             do_rd;

  // writes into a full fifo are dropped, reads from empty do nothing
  assign do_wr = wr_en_in && !st_ff.full;
  assign do_rd = rd_en_in && !st_ff.empty;

  always_comb begin
    logic [ADDR_W:0] wp;
    logic [ADDR_W:0] rp;
    wp = st_ff.wr_ptr + (ADDR_W+1)'(do_wr);
    rp = st_ff.rd_ptr + (ADDR_W+1)'(do_rd);
    nxt_st          = st_ff;
    nxt_st.wr_ptr   = wp;
    nxt_st.rd_ptr   = rp;
    nxt_st.rd_valid = do_rd;
    if (do_rd) begin
      nxt_st.rd_data = mem[st_ff.rd_ptr[ADDR_W-1:0]];
    end
    nxt_st.empty = (wp == rp);
    nxt_st.full  = (wp[ADDR_W] != rp[ADDR_W]) && (wp[ADDR_W-1:0] == rp[ADDR_W-1:0]);
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '{wr_ptr: '0, rd_ptr: '0, rd_data: '0, rd_valid: 1'b0,
                 full: 1'b0, empty: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (do_wr) begin
      mem[st_ff.wr_ptr[ADDR_W-1:0]] <= wr_data_in;
    end
  end

  assign rd_data_out  = st_ff.rd_data;
  assign rd_valid_out = st_ff.rd_valid;
  assign full_out     = st_ff.full;
  assign empty_out    = st_ff.empty;

endmodule
`default_nettype wire

//--- verilog/serial_lane_crossbar_status.sv
// lane crossbar, lane fifo flags, sync error pulse and phy setup registers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - each logical lane reads its selected physical input
// - source selects reset to identity mapping
// - full flag vector, bit per logical lane
// - empty flag vector, bit per logical lane
// - multiframe end after errors raises sync error
// - prbs test runs only on enabled lanes
// - lanes zero and one mapped likewise, identity reset
module serial_lane_crossbar_status #(
  parameter int LANE_DATA_W = 32,
  parameter int FIFO_ADDR_W = 2
) (
  // clock and reset
  input  wire logic                                   mclk_in,
  input  wire logic                                   arst_n_in,
  // apb slave
  input  wire logic                                   psel_in,
  input  wire logic                                   penable_in,
  input  wire logic                                   pwrite_in,
  input  wire logic [serial_lane_pkg::APB_AW-1:0]     paddr_in,
  input  wire logic [serial_lane_pkg::APB_DW-1:0]     pwdata_in,
  output logic      [serial_lane_pkg::APB_DW-1:0]     prdata_out,
  output logic                                        pready_out,
  output logic                                        pslverr_out,
  // physical serial inputs, deserialised
  input  wire logic [serial_lane_pkg::LANES-1:0][LANE_DATA_W-1:0] serial_input_pair_in,
  input  wire logic [serial_lane_pkg::LANES-1:0]      serial_input_valid_in,
  // decoder errors per logical lane and multiframe end strobe
  input  wire serial_lane_pkg::lane_err_t             lane_err_in,
  input  wire logic                                   multiframe_end_in,
  // logical lane read side
  input  wire logic [serial_lane_pkg::LANES-1:0]      lane_rd_en_in,
  output logic [serial_lane_pkg::LANES-1:0][LANE_DATA_W-1:0] lane_data_out,
  output logic [serial_lane_pkg::LANES-1:0]           lane_valid_out,
  // sync outputs, active low
  output logic                                        sync_output_a_n_out,
  output logic                                        sync_output_b_n_out,
  // phy configuration
  output logic [serial_lane_pkg::REG_W-1:0]           phy_setup_value_out,
  output logic [serial_lane_pkg::LANES-1:0]           prbs_lane_enables_out,
  // interrupt
  output logic                                        irq_out
);

  typedef struct packed {
    serial_lane_pkg::lane_map_t                        lane_map;
    logic [serial_lane_pkg::SYNC_LEN_W-1:0]            sync_len;
    logic [serial_lane_pkg::REG_W-1:0]                 phy_setup;
    logic [serial_lane_pkg::REG_W-1:0]                 prbs_en;
    logic [serial_lane_pkg::PRBS_CTRL_W-1:0]           prbs_ctrl;
    logic [serial_lane_pkg::IRQ_W-1:0]                 irq_status;
    logic [serial_lane_pkg::IRQ_W-1:0]                 irq_mask;
    logic                                              irq;
    logic                                              err_seen;
    serial_lane_pkg::sync_state_t                      sync_state;
    logic [serial_lane_pkg::SYNC_LEN_W-1:0]            sync_cnt;
    logic                                              sync_n;
    logic                                              pready;
    logic                                              pslverr;
    logic [serial_lane_pkg::APB_DW-1:0]                prdata;
    logic [serial_lane_pkg::LANES-1:0]                 full_q;
    logic [serial_lane_pkg::LANES-1:0]                 empty_q;
  } top_state_t;

  top_state_t                                          st_ff;
  top_state_t                                          nxt_st;
  logic [serial_lane_pkg::LANES-1:0][LANE_DATA_W-1:0]  xbar_data;
  logic [serial_lane_pkg::LANES-1:0]                   xbar_valid;
  logic [serial_lane_pkg::LANES-1:0]                   fifo_full;
  logic [serial_lane_pkg::LANES-1:0]                   fifo_empty;

  // crossbar: logical lane l takes the physical input its field names
  always_comb begin
    for (int l = 0; l < serial_lane_pkg::LANES; l++) begin
      xbar_data[l]  = serial_input_pair_in[serial_lane_pkg::lane_src(st_ff.lane_map, l)];
      xbar_valid[l] = serial_input_valid_in[serial_lane_pkg::lane_src(st_ff.lane_map, l)];
    end
  end

  for (genvar g = 0; g < serial_lane_pkg::LANES; g++) begin : g_lane
    lane_fifo #(
      .DATA_W (LANE_DATA_W),
      .ADDR_W (FIFO_ADDR_W)
    ) u_fifo (
      .mclk_in      (mclk_in),
      .arst_n_in    (arst_n_in),
      .wr_en_in     (xbar_valid[g]),
      .wr_data_in   (xbar_data[g]),
      .rd_en_in     (lane_rd_en_in[g]),
      .rd_data_out  (lane_data_out[g]),
      .rd_valid_out (lane_valid_out[g]),
      .full_out     (fifo_full[g]),
      .empty_out    (fifo_empty[g])
    );
  end

  always_comb begin
    logic                                   access;
    logic                                   wr_hit;
    logic [serial_lane_pkg::IDX_W-1:0]      idx;
    logic [serial_lane_pkg::APB_DW-1:0]     rdata;
    logic                                   hit;
    logic                                   any_err;
    logic [serial_lane_pkg::IRQ_W-1:0]      events;
    logic [serial_lane_pkg::IRQ_W-1:0]      clr;
    logic [serial_lane_pkg::IRQ_W-1:0]      new_mask;
    access   = 1'b0;
    wr_hit   = 1'b0;
    idx      = paddr_in[serial_lane_pkg::IDX_LSB +: serial_lane_pkg::IDX_W];
    rdata    = '0;
    hit      = 1'b1;
    any_err  = 1'b0;
    events   = '0;
    clr      = '0;
    new_mask = st_ff.irq_mask;
    nxt_st   = st_ff;

    // read mux, reserved and upper bits read zero
    case (idx)
      serial_lane_pkg::IDX_LANE_MAP_0_1: rdata[5:0] = st_ff.lane_map[0][5:0];
      serial_lane_pkg::IDX_LANE_MAP_2_3: rdata[5:0] = st_ff.lane_map[1][5:0];
      serial_lane_pkg::IDX_LANE_MAP_4_5: rdata[5:0] = st_ff.lane_map[2][5:0];
      serial_lane_pkg::IDX_LANE_MAP_6_7: rdata[5:0] = st_ff.lane_map[3][5:0];
      serial_lane_pkg::IDX_FIFO_FULL:    rdata[7:0] = fifo_full;
      serial_lane_pkg::IDX_FIFO_EMPTY:   rdata[7:0] = fifo_empty;
      serial_lane_pkg::IDX_SYNC_CFG:
        rdata[serial_lane_pkg::SYNC_LEN_LSB +: serial_lane_pkg::SYNC_LEN_W] = st_ff.sync_len;
      serial_lane_pkg::IDX_PHY_SETUP:    rdata[7:0] = st_ff.phy_setup;
      serial_lane_pkg::IDX_PRBS_EN:      rdata[7:0] = st_ff.prbs_en;
      serial_lane_pkg::IDX_PRBS_CTRL:    rdata[6:0] = st_ff.prbs_ctrl;
      serial_lane_pkg::IDX_IRQ_STATUS:   rdata[2:0] = st_ff.irq_status;
      serial_lane_pkg::IDX_IRQ_MASK:     rdata[2:0] = st_ff.irq_mask;
      default:                           hit = 1'b0;
    endcase

    // apb: answer registered in the cycle after setup
    if (psel_in && !penable_in) begin
      nxt_st.pready  = 1'b1;
      nxt_st.prdata  = pwrite_in ? '0 : rdata;
      nxt_st.pslverr = !hit;
    end else if (psel_in && penable_in && st_ff.pready) begin
      access         = 1'b1;
      nxt_st.pready  = 1'b0;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata  = '0;
    end else begin
      nxt_st.pready  = 1'b0;
      nxt_st.pslverr = 1'b0;
    end
    wr_hit = access && pwrite_in;

    // register writes; flag registers have no write path
    if (wr_hit) begin
      case (idx)
        serial_lane_pkg::IDX_LANE_MAP_0_1: nxt_st.lane_map[0] = {2'h0, pwdata_in[5:0]};
        serial_lane_pkg::IDX_LANE_MAP_2_3: nxt_st.lane_map[1] = {2'h0, pwdata_in[5:0]};
        serial_lane_pkg::IDX_LANE_MAP_4_5: nxt_st.lane_map[2] = {2'h0, pwdata_in[5:0]};
        serial_lane_pkg::IDX_LANE_MAP_6_7: nxt_st.lane_map[3] = {2'h0, pwdata_in[5:0]};
        serial_lane_pkg::IDX_SYNC_CFG:
          nxt_st.sync_len =
            pwdata_in[serial_lane_pkg::SYNC_LEN_LSB +: serial_lane_pkg::SYNC_LEN_W];
        serial_lane_pkg::IDX_PHY_SETUP:    nxt_st.phy_setup = pwdata_in[7:0];
        serial_lane_pkg::IDX_PRBS_EN:      nxt_st.prbs_en   = pwdata_in[7:0];
        serial_lane_pkg::IDX_PRBS_CTRL:    nxt_st.prbs_ctrl = pwdata_in[6:0];
        serial_lane_pkg::IDX_IRQ_STATUS:   clr = pwdata_in[2:0];
        serial_lane_pkg::IDX_IRQ_MASK:     new_mask = pwdata_in[2:0];
        default:                           clr = '0;
      endcase
    end

    // errors collected over the multiframe, end cycle included
    any_err = |lane_err_in.disparity || |lane_err_in.not_in_table ||
              |lane_err_in.unexp_ctrl;
    if (multiframe_end_in) begin
      nxt_st.err_seen = 1'b0;
    end else begin
      nxt_st.err_seen = st_ff.err_seen || any_err;
    end

    // sync error pulse on both outputs
    case (st_ff.sync_state)
      serial_lane_pkg::SYNC_IDLE: begin
        nxt_st.sync_n = 1'b1;
        if (multiframe_end_in && (st_ff.err_seen || any_err)) begin
          nxt_st.sync_state = serial_lane_pkg::SYNC_LOW;
          nxt_st.sync_n     = 1'b0;
          nxt_st.sync_cnt   = serial_lane_pkg::pulse_cycles(st_ff.sync_len) - 2'h1;
          events[serial_lane_pkg::IRQ_SYNC] = 1'b1;
        end
      end
      serial_lane_pkg::SYNC_LOW: begin
        if (st_ff.sync_cnt == '0) begin
          nxt_st.sync_state = serial_lane_pkg::SYNC_IDLE;
          nxt_st.sync_n     = 1'b1;
        end else begin
          nxt_st.sync_cnt   = st_ff.sync_cnt - 2'h1;
          nxt_st.sync_n     = 1'b0;
        end
      end
      default: begin
        nxt_st.sync_state = serial_lane_pkg::SYNC_IDLE;
        nxt_st.sync_n     = 1'b1;
      end
    endcase

    // fifo fault events on a lane going full or empty
    nxt_st.full_q  = fifo_full;
    nxt_st.empty_q = fifo_empty;
    events[serial_lane_pkg::IRQ_FULL]  = |(fifo_full & ~st_ff.full_q);
    events[serial_lane_pkg::IRQ_EMPTY] = |(fifo_empty & ~st_ff.empty_q);

    // sticky status, set beats write-one clear
    nxt_st.irq_status = (st_ff.irq_status & ~clr) | events;
    nxt_st.irq_mask   = new_mask;
    nxt_st.irq        = |(nxt_st.irq_status & new_mask);
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff.lane_map   <= {serial_lane_pkg::MAP_6_7_RST, serial_lane_pkg::MAP_4_5_RST,
                           serial_lane_pkg::MAP_2_3_RST, serial_lane_pkg::MAP_0_1_RST};
      st_ff.sync_len   <= serial_lane_pkg::SYNC_LEN_RST;
      st_ff.phy_setup  <= serial_lane_pkg::PHY_SETUP_RST;
      st_ff.prbs_en    <= serial_lane_pkg::PRBS_EN_RST;
      st_ff.prbs_ctrl  <= serial_lane_pkg::PRBS_CTRL_RST;
      st_ff.irq_status <= serial_lane_pkg::IRQ_RST;
      st_ff.irq_mask   <= serial_lane_pkg::IRQ_RST;
      st_ff.irq        <= 1'b0;
      st_ff.err_seen   <= 1'b0;
      st_ff.sync_state <= serial_lane_pkg::SYNC_IDLE;
      st_ff.sync_cnt   <= '0;
      st_ff.sync_n     <= 1'b1;
      st_ff.pready     <= 1'b0;
      st_ff.pslverr    <= 1'b0;
      st_ff.prdata     <= '0;
      st_ff.full_q     <= '0;
      st_ff.empty_q    <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata_out            = st_ff.prdata;
  assign pready_out            = st_ff.pready;
  assign pslverr_out           = st_ff.pslverr;
  assign sync_output_a_n_out   = st_ff.sync_n;
  assign sync_output_b_n_out   = st_ff.sync_n;
  assign phy_setup_value_out   = st_ff.phy_setup;
  assign prbs_lane_enables_out = st_ff.prbs_en;
  assign irq_out               = st_ff.irq;

endmodule
`default_nettype wire

//--- tb/lane_tx_model.sv
// far-side transmitter model: lane words, decoder errors, multiframe ends
`timescale 1ns/1ps
`default_nettype none
module lane_tx_model (
  // clock
  input  wire logic                  mclk_in,
  // lane stream toward the receiver
  output logic [7:0][31:0]           words_out,
  output logic [7:0]                 valid_out,
  output serial_lane_pkg::lane_err_t err_out,
  output logic                       mf_end_out
);
  initial begin
    words_out  = '0;
    valid_out  = 8'h00;
    err_out    = '0;
    mf_end_out = 1'b0;
  end
  task automatic send(input logic [7:0][31:0] d);
    words_out <= d;
    valid_out <= 8'hFF;
    @(posedge mclk_in);
  endtask
  // released lines show the inverse of the last word
  task automatic idle();
    valid_out <= 8'h00;
    words_out <= ~words_out;
    @(posedge mclk_in);
  endtask
  task automatic err(input int kind, input int lane);
    serial_lane_pkg::lane_err_t e;
    e = '0;
    case (kind)
      0: e.disparity[lane] = 1'b1;
      1: e.not_in_table[lane] = 1'b1;
      default: e.unexp_ctrl[lane] = 1'b1;
    endcase
    err_out <= e;
    @(posedge mclk_in);
    err_out <= '0;
    @(posedge mclk_in);
  endtask
  task automatic mf_end();
    mf_end_out <= 1'b1;
    @(posedge mclk_in);
    mf_end_out <= 1'b0;
    @(posedge mclk_in);
  endtask
endmodule
`default_nettype wire

//--- tb/serial_lane_crossbar_status_checker.sv
// port-level assertions for the serial lane crossbar and status block
`timescale 1ns/1ps
`default_nettype none
module serial_lane_crossbar_status_checker (
  // clock and reset
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  // apb
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // lanes, sync, config
  input wire logic        multiframe_end_in,
  input wire logic [7:0]  lane_rd_en_in,
  input wire logic [7:0]  lane_valid_out,
  input wire logic        sync_output_a_n_out,
  input wire logic        sync_output_b_n_out,
  input wire logic [7:0]  prbs_lane_enables_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  AST_READY_AFTER_SETUP:
    assert property (psel_in && !penable_in |=> pready_out) else $error("no ready after setup");
  AST_READY_ONE_CYCLE:
    assert property (pready_out |=> !pready_out) else $error("ready held too long");
  AST_RDATA_IDLE:
    assert property (!pready_out |-> prdata_out == 32'h0) else $error("read data outside access");
  AST_ERR_WITH_READY:
    assert property (pslverr_out |-> pready_out) else $error("error without ready");
  AST_SYNC_PAIR:
    assert property (sync_output_a_n_out == sync_output_b_n_out) else $error("sync outputs differ");
  AST_SYNC_MAX_TWO:
    assert property (!sync_output_a_n_out ##1 !sync_output_a_n_out |=> sync_output_a_n_out)
      else $error("sync low over two cycles");
  AST_SYNC_CAUSE:
    assert property ($fell(sync_output_a_n_out) |-> $past(multiframe_end_in))
      else $error("sync low without multiframe end");
  AST_POP_CAUSE:
    assert property (lane_valid_out != 8'h00 |-> (lane_valid_out & ~$past(lane_rd_en_in)) == 8'h00)
      else $error("lane word without pop");
  AST_PRBS_WRITE:
    assert property (!$stable(prbs_lane_enables_out)
      |-> $past(psel_in && penable_in && pwrite_in && pready_out)) else $error("enables moved");
  cover property (!sync_output_a_n_out ##1 !sync_output_a_n_out);
  cover property (pslverr_out);
  cover property (lane_valid_out == 8'hFF);
endmodule
bind serial_lane_crossbar_status serial_lane_crossbar_status_checker
  serial_lane_crossbar_status_checker_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .multiframe_end_in(multiframe_end_in),
  .lane_rd_en_in(lane_rd_en_in), .lane_valid_out(lane_valid_out),
  .sync_output_a_n_out(sync_output_a_n_out), .sync_output_b_n_out(sync_output_b_n_out),
  .prbs_lane_enables_out(prbs_lane_enables_out));
`default_nettype wire

//--- tb/serial_lane_crossbar_status_bench.sv
// self-checking bench for the serial lane crossbar and status block
`timescale 1ns/1ps
`default_nettype none
module serial_lane_crossbar_status_bench;
  logic                       mclk;
  logic                       arst_n;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [11:0]                paddr;
  logic [31:0]                pwdata;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [7:0][31:0]           words;
  logic [7:0]                 wvalid;
  serial_lane_pkg::lane_err_t lerr;
  logic                       mf_end;
  logic [7:0]                 rd_en;
  logic [7:0][31:0]           ldata;
  logic [7:0]                 lvalid;
  logic                       sync_a_n;
  logic                       sync_b_n;
  logic [7:0]                 phy;
  logic [7:0]                 prbs;
  logic                       irq;
  int                         fails;
  int                         checked;
  int                         lowcnt;
  int                         j;
  int                         q[8][$];
  logic [2:0]                 src[8];
  logic [2:0]                 t;
  logic [31:0]                seed;
  logic [31:0]                rd;
  logic                       err;
  logic [7:0][31:0]           dw;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  serial_lane_crossbar_status #(.LANE_DATA_W(32), .FIFO_ADDR_W(2)) serial_lane_crossbar_status_i (
    .mclk_in(mclk), .arst_n_in(arst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .serial_input_pair_in(words),
    .serial_input_valid_in(wvalid), .lane_err_in(lerr), .multiframe_end_in(mf_end),
    .lane_rd_en_in(rd_en), .lane_data_out(ldata), .lane_valid_out(lvalid),
    .sync_output_a_n_out(sync_a_n), .sync_output_b_n_out(sync_b_n),
    .phy_setup_value_out(phy), .prbs_lane_enables_out(prbs), .irq_out(irq));
  lane_tx_model lane_tx_model_i (.mclk_in(mclk), .words_out(words), .valid_out(wvalid),
    .err_out(lerr), .mf_end_out(mf_end));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // expected flag vector from the queue model
  function automatic logic [31:0] flags(input int full);
    logic [31:0] f;
    f = 32'h0;
    for (int l = 0; l < 8; l++) f[l] = full ? (q[l].size() == 4) : (q[l].size() == 0);
    return f;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic sync_len(input logic [31:0] exp);
    lowcnt = 0;
    repeat (4) begin
      if (sync_a_n === 1'b0) lowcnt++;
      @(posedge mclk);
    end
    chk(32'(lowcnt), exp);
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    fails = 0;
    checked = 0;
    seed = 32'h501FA524;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rd_en = 8'h00;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 10'(serial_lane_pkg::IDX_LANE_MAP_0_1 + i), 32'h0);
      chk(rd, {26'h0, 3'(2 * i + 1), 3'(2 * i)});
    end
    apb(1'b0, serial_lane_pkg::IDX_FIFO_EMPTY, 32'h0);
    chk(rd, flags(0));
    apb(1'b0, serial_lane_pkg::IDX_PHY_SETUP, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 10'h3FF, 32'hFF);
    chk(32'(err), 32'h1);
    apb(1'b1, serial_lane_pkg::IDX_FIFO_EMPTY, 32'h0);
    apb(1'b0, serial_lane_pkg::IDX_FIFO_EMPTY, 32'h0);
    chk(rd, 32'hFF);
    apb(1'b1, serial_lane_pkg::IDX_PHY_SETUP, 32'h01);
    chk(32'(phy), 32'h01);
    seed = xs(seed);
    apb(1'b1, serial_lane_pkg::IDX_PRBS_EN, seed);
    chk(32'(prbs), 32'(seed[7:0]));
    apb(1'b1, serial_lane_pkg::IDX_PRBS_CTRL, 32'hFF);
    apb(1'b0, serial_lane_pkg::IDX_PRBS_CTRL, 32'h0);
    chk(rd, 32'h7F);
    for (int i = 0; i < 8; i++) src[i] = 3'(i);
    for (int i = 7; i > 0; i--) begin
      seed = xs(seed);
      j = int'(seed % 32'(i + 1));
      t = src[i];
      src[i] = src[j];
      src[j] = t;
    end
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 10'(serial_lane_pkg::IDX_LANE_MAP_0_1 + r), {26'h0, src[2 * r + 1], src[2 * r]});
      apb(1'b0, 10'(serial_lane_pkg::IDX_LANE_MAP_0_1 + r), 32'h0);
      chk(rd, {26'h0, src[2 * r + 1], src[2 * r]});
    end
    repeat (5) begin
      for (int p = 0; p < 8; p++) begin
        seed = xs(seed);
        dw[p] = seed;
      end
      for (int l = 0; l < 8; l++) if (q[l].size() < 4) q[l].push_back(dw[src[l]]);
      lane_tx_model_i.send(dw);
    end
    lane_tx_model_i.idle();
    apb(1'b0, serial_lane_pkg::IDX_FIFO_FULL, 32'h0);
    chk(rd, flags(1));
    apb(1'b0, serial_lane_pkg::IDX_IRQ_STATUS, 32'h0);
    chk(rd, 32'h2);
    repeat (5) begin
      rd_en <= 8'hFF;
      @(posedge mclk);
      rd_en <= 8'h00;
      @(posedge mclk);
      chk(32'(lvalid), flags(0) == 32'hFF ? 32'h0 : 32'hFF);
      for (int l = 0; l < 8; l++) if (q[l].size() > 0) chk(ldata[l], q[l].pop_front());
    end
    apb(1'b0, serial_lane_pkg::IDX_FIFO_EMPTY, 32'h0);
    chk(rd, flags(0));
    apb(1'b1, serial_lane_pkg::IDX_IRQ_MASK, 32'h1);
    apb(1'b1, serial_lane_pkg::IDX_IRQ_STATUS, 32'h7);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, serial_lane_pkg::IDX_SYNC_CFG, 32'(k) << 4);
      lane_tx_model_i.err(k % 3, 2 * k + 1);
      lane_tx_model_i.mf_end();
      sync_len(k < 2 ? 32'h1 : 32'h2);
      chk(32'(irq), 32'h1);
      apb(1'b1, serial_lane_pkg::IDX_IRQ_STATUS, 32'h1);
      @(posedge mclk);
      chk(32'(irq), 32'h0);
    end
    lane_tx_model_i.mf_end();
    sync_len(32'h0);
    apb(1'b1, serial_lane_pkg::IDX_IRQ_MASK, 32'h0);
    lane_tx_model_i.err(0, 0);
    lane_tx_model_i.mf_end();
    sync_len(32'h2);
    chk(32'(irq), 32'h0);
    apb(1'b0, serial_lane_pkg::IDX_IRQ_STATUS, 32'h0);
    chk(32'(rd[0]), 32'h1);
    apb(1'b0, serial_lane_pkg::IDX_SYNC_CFG, 32'h0);
    chk(rd, 32'h30);
    // mid-run reset restores identity map and phy setup
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk(32'(phy), 32'h0);
    apb(1'b0, serial_lane_pkg::IDX_LANE_MAP_6_7, 32'h0);
    chk(rd, 32'h3E);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
